//--- logic/nvm_defines.svh
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH

// Register indices on the plain register port
`define NVM_ADR_DATA_LOW    3'h0
`define NVM_ADR_DATA_HIGH   3'h1
`define NVM_ADR_ADDR_LOW    3'h2
`define NVM_ADR_ADDR_HIGH   3'h3
`define NVM_ADR_CONTROL     3'h4
`define NVM_ADR_UNLOCK      3'h5
`define NVM_ADR_STATUS      3'h6

// Control register bit positions
`define NVM_BIT_SPACE       7
`define NVM_BIT_ABORT       3
`define NVM_BIT_WRITE_ENABLE_BIT        2
`define NVM_BIT_WR          1
`define NVM_BIT_RD          0
// Status register bit position
`define NVM_BIT_DONE        0

// Unlock key values
`define NVM_KEY_FIRST       8'h55
`define NVM_KEY_SECOND      8'haa

// Memory geometry
`define NVM_EE_DEPTH        64
`define NVM_FL_DEPTH        2048
`define NVM_FL_DATA_W       14

// Timing: core clock period and programming time
`define NVM_CLK_PERIOD_NS   40
`define NVM_WRITE_TIME_US   4000
`define NVM_WRITE_CYCLES    ((`NVM_WRITE_TIME_US * 1000) / `NVM_CLK_PERIOD_NS)
`define NVM_FL_READ_CYCLES  2
`define NVM_FL_PREP_CYCLES  2

// Reset values
`define NVM_BYTE_ZERO       8'h00

`endif

//--- logic/nvm_pkg.sv
package nvm_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FL_READ,
    ST_FL_PREP,
    ST_EE_PROG,
    ST_FL_PROG
  } seq_state_t;

  // Progress through the unlock key sequence
  typedef enum logic [1:0] {
    LK_IDLE,
    LK_FIRST,
    LK_ARMED
  } lock_state_t;

endpackage : nvm_pkg

//--- logic/nvm_sync.sv
`timescale 1ns/1ns
// Two flip-flop level synchroniser
module nvm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : nvm_sync

//--- logic/nvm_read_write_sequencer.sv
`timescale 1ns/1ns
`include "nvm_defines.svh"
// Summary of operation
// [RQ1] Firmware loads address and data, selects space, sets write enable before starting.
// [RQ2] Write start honoured only if write enable was set by an earlier write.
// [RQ3] Clearing write enable during a write does not abort it.
// [RQ4] Each write needs 55h then AAh to the unlock port, then write start.
// [RQ5] Firmware disables interrupts around the unlock sequence.
// [RQ6] On completion hardware clears write start and sets a sticky done flag.
// [RQ7] Firmware polls done flag or write start bit for the end of a write.
// [RQ8] Data memory write programs the low data byte at the low address.
// [RQ9] Space select zero picks data memory, one picks program memory.
// [RQ10] Program read presents both data registers after two instruction cycles.
// [RQ11] Data registers hold a read value until next read or firmware write.
// [RQ12] Program write stalls instruction execution; interrupts stay pending.
// [RQ13] Two cycles after a program write start are used to prepare it.
// [RQ14] After a program write, execution resumes after the second no-op.
// [RQ15] Program writes are blocked while the write permit bit is zero.
// [RQ16] Program write stores a 14-bit word from both data registers.
// [RQ17] Firmware keeps write enable cleared except around a write.
// [RQ18] Write start without the preceding unlock pair is ignored.
// [RQ19] Data memory holds 64 bytes; larger addresses wrap to zero.
// [RQ20] Program addresses span 0000h to 07FFh and wrap beyond.
// [RQ21] Warm reset during a write sets abort flag; address, data, select survive.
// [RQ22] Data memory read loads the low data register the next cycle.
module nvm_read_write_sequencer #(
  parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES,
  parameter int EE_DEPTH     = `NVM_EE_DEPTH,
  parameter int FL_DEPTH     = `NVM_FL_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       warm_rst,
  input  wire logic       program_write_permit,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            core_stall,
  output logic            write_done
);

  localparam int EE_AW = $clog2(EE_DEPTH);
  localparam int FL_AW = $clog2(FL_DEPTH);
  localparam int FL_W  = `NVM_FL_DATA_W;
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  // Memories
  logic [7:0]      ee_mem [EE_DEPTH];
  logic [FL_W-1:0] fl_mem [FL_DEPTH];

  // Software visible state
  logic [7:0]      data_low_reg;
  logic [7:0]      data_high_reg;
  logic [7:0]      addr_low_reg;
  logic [7:0]      addr_high_reg;
  logic            mss_reg;
  logic            abort_reg;
  logic            write_enable_bit_reg;
  logic            wr_reg;
  logic            rd_reg;
  logic            write_done_reg;

  // Sequencer state
  nvm_pkg::seq_state_t  state_reg;
  nvm_pkg::seq_state_t  state_next;
  nvm_pkg::lock_state_t lock_reg;
  nvm_pkg::lock_state_t lock_next;
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     cnt_next;
  logic [EE_AW-1:0]     ee_wr_addr_reg;
  logic [FL_AW-1:0]     fl_wr_addr_reg;
  logic [FL_W-1:0]      wr_word_reg;
  logic                 permit_sync;

  // Configuration bit arrives from outside the core clock domain
  nvm_sync #(
    .WIDTH (1)
  ) u_permit_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (program_write_permit),
    .sync_out (permit_sync)
  );

  // Address decode of register writes
  wire wr_dl   = reg_wr && (reg_addr == `NVM_ADR_DATA_LOW);
  wire wr_dh   = reg_wr && (reg_addr == `NVM_ADR_DATA_HIGH);
  wire wr_al   = reg_wr && (reg_addr == `NVM_ADR_ADDR_LOW);
  wire wr_ah   = reg_wr && (reg_addr == `NVM_ADR_ADDR_HIGH);
  wire wr_ctl  = reg_wr && (reg_addr == `NVM_ADR_CONTROL);
  wire wr_key  = reg_wr && (reg_addr == `NVM_ADR_UNLOCK);
  wire wr_stat = reg_wr && (reg_addr == `NVM_ADR_STATUS);

  // Wrapped addresses: upper bits are simply not decoded
  wire [EE_AW-1:0] ee_addr = addr_low_reg[EE_AW-1:0]; // [RQ19]
  wire [15:0]      addr_pair = {addr_high_reg, addr_low_reg};
  wire [FL_AW-1:0] fl_addr = addr_pair[FL_AW-1:0]; // [RQ20]
  wire [7:0]       ee_word = ee_mem[ee_addr];
  wire [FL_W-1:0]  fl_word = fl_mem[fl_addr];

  // Start qualification
  wire idle       = (state_reg == nvm_pkg::ST_IDLE);
  wire rd_req     = wr_ctl && reg_wdata[`NVM_BIT_RD] && idle;
  wire rd_start   = rd_req;
  wire wr_req     = wr_ctl && reg_wdata[`NVM_BIT_WR] && idle && !rd_req;
  wire key_ok     = (lock_reg == nvm_pkg::LK_ARMED); // [RQ4] [RQ18]
  wire permit_ok  = !mss_reg || permit_sync; // [RQ15]
  wire wr_start   = wr_req && write_enable_bit_reg && key_ok && permit_ok; // [RQ1] [RQ2]
  wire ee_rd_load = rd_start && !mss_reg; // [RQ9] [RQ22]
  wire fl_rd_load = (state_reg == nvm_pkg::ST_FL_READ)
                    && (cnt_reg == CNT_W'(`NVM_FL_READ_CYCLES - 1)); // [RQ10]
  wire prep_last  = (state_reg == nvm_pkg::ST_FL_PREP)
                    && (cnt_reg == CNT_W'(`NVM_FL_PREP_CYCLES - 1)); // [RQ13]
  wire prog_last  = (cnt_reg == CNT_W'(WRITE_CYCLES - 1));
  wire ee_done    = (state_reg == nvm_pkg::ST_EE_PROG) && prog_last;
  wire fl_done    = (state_reg == nvm_pkg::ST_FL_PROG) && prog_last;
  wire prog_done  = (ee_done || fl_done) && !warm_rst;
  wire busy       = !idle;

  // Unlock tracker: any other register write breaks the pair
  always_comb begin
    lock_next = nvm_pkg::LK_IDLE;
    if (wr_key && reg_wdata == `NVM_KEY_FIRST) begin
      lock_next = nvm_pkg::LK_FIRST;
    end else if (wr_key && reg_wdata == `NVM_KEY_SECOND && lock_reg == nvm_pkg::LK_FIRST) begin
      lock_next = nvm_pkg::LK_ARMED; // [RQ4]
    end else if (!reg_wr) begin
      lock_next = lock_reg;
    end
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      nvm_pkg::ST_IDLE: begin
        if (rd_start && mss_reg) begin
          state_next = nvm_pkg::ST_FL_READ;
        end else if (wr_start && mss_reg) begin
          state_next = nvm_pkg::ST_FL_PREP;
        end else if (wr_start) begin
          state_next = nvm_pkg::ST_EE_PROG;
        end
      end
      nvm_pkg::ST_FL_READ: begin
        if (fl_rd_load) begin
          state_next = nvm_pkg::ST_IDLE;
        end
      end
      nvm_pkg::ST_FL_PREP: begin
        if (prep_last) begin
          state_next = nvm_pkg::ST_FL_PROG;
        end
      end
      nvm_pkg::ST_EE_PROG,
      nvm_pkg::ST_FL_PROG: begin
        if (prog_last) begin
          state_next = nvm_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Counter restarts on each state change
  assign cnt_next = (state_next != state_reg) ? '0 : cnt_reg + CNT_W'(1);

  // Sequencer and unlock registers; warm reset aborts any cycle in flight
  always_ff @(posedge ref_clk) begin
    if (sys_rst || warm_rst) begin
      state_reg  <= nvm_pkg::ST_IDLE;
      lock_reg   <= nvm_pkg::LK_IDLE;
      cnt_reg    <= '0;
      core_stall <= 1'b0;
    end else begin
      state_reg  <= state_next;
      lock_reg   <= lock_next;
      cnt_reg    <= cnt_next;
      core_stall <= (state_next == nvm_pkg::ST_FL_PROG); // [RQ12] [RQ14]
    end
  end

  // Write operands captured at start, so later register writes cannot disturb them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ee_wr_addr_reg <= '0;
      fl_wr_addr_reg <= '0;
      wr_word_reg    <= '0;
    end else if (wr_start) begin
      ee_wr_addr_reg <= ee_addr; // [RQ8]
      fl_wr_addr_reg <= fl_addr; // [RQ16]
      wr_word_reg    <= mss_reg ? {data_high_reg[FL_W-9:0], data_low_reg}
                                : {{(FL_W-8){1'b0}}, data_low_reg}; // [RQ8] [RQ16]
    end
  end

  // Array programming at the end of the cycle; an aborted cycle writes nothing
  always_ff @(posedge ref_clk) begin
    if (ee_done && !warm_rst && !sys_rst) begin
      ee_mem[ee_wr_addr_reg] <= wr_word_reg[7:0]; // [RQ8]
    end
    if (fl_done && !warm_rst && !sys_rst) begin
      fl_mem[fl_wr_addr_reg] <= wr_word_reg; // [RQ16]
    end
  end

  // Data and address registers; read loads take priority over firmware writes
  wire [7:0] data_low_next  = ee_rd_load ? ee_word
                            : fl_rd_load ? fl_word[7:0]
                            : wr_dl      ? reg_wdata : data_low_reg; // [RQ11] [RQ22]
  wire [7:0] data_high_next = fl_rd_load ? {{(16-FL_W){1'b0}}, fl_word[FL_W-1:8]}
                            : wr_dh      ? reg_wdata : data_high_reg; // [RQ10] [RQ11]

  // These survive warm reset so firmware can retry an aborted write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_low_reg  <= `NVM_BYTE_ZERO;
      data_high_reg <= `NVM_BYTE_ZERO;
      addr_low_reg  <= `NVM_BYTE_ZERO;
      addr_high_reg <= `NVM_BYTE_ZERO;
      mss_reg       <= 1'b0;
    end else begin
      data_low_reg  <= data_low_next;
      data_high_reg <= data_high_next;
      addr_low_reg  <= wr_al ? reg_wdata : addr_low_reg;
      addr_high_reg <= wr_ah ? reg_wdata : addr_high_reg;
      if (wr_ctl && idle) begin
        mss_reg <= reg_wdata[`NVM_BIT_SPACE]; // [RQ9]
      end
    end
  end

  // Control bits: write enable is plain storage, start bits set only, cleared by hardware
  wire abort_next = (warm_rst && wr_reg)
                 || (wr_ctl ? reg_wdata[`NVM_BIT_ABORT] : abort_reg); // [RQ21]
  wire done_next  = prog_done
                 || (wr_stat ? reg_wdata[`NVM_BIT_DONE] && write_done_reg
                             : write_done_reg); // [RQ6]

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      write_enable_bit_reg       <= 1'b0;
      wr_reg         <= 1'b0;
      rd_reg         <= 1'b0;
      abort_reg      <= 1'b0;
      write_done_reg <= 1'b0;
    end else if (warm_rst) begin
      write_enable_bit_reg       <= 1'b0;
      wr_reg         <= 1'b0;
      rd_reg         <= 1'b0;
      abort_reg      <= abort_next; // [RQ21]
      write_done_reg <= write_done_reg;
    end else begin
      write_enable_bit_reg       <= wr_ctl ? reg_wdata[`NVM_BIT_WRITE_ENABLE_BIT] : write_enable_bit_reg; // [RQ3]
      wr_reg         <= wr_start || (wr_reg && !prog_done); // [RQ6]
      rd_reg         <= (rd_start && mss_reg) || (rd_reg && !fl_rd_load);
      abort_reg      <= abort_next;
      write_done_reg <= done_next; // [RQ6]
    end
  end

  // Read mux; the unlock port is not storage and reads as zero
  wire [7:0] ctl_view = {mss_reg, 3'h0, abort_reg, write_enable_bit_reg, wr_reg, rd_reg};
  wire [7:0] rd_mux   = (reg_addr == `NVM_ADR_DATA_LOW)  ? data_low_reg
                      : (reg_addr == `NVM_ADR_DATA_HIGH) ? data_high_reg
                      : (reg_addr == `NVM_ADR_ADDR_LOW)  ? addr_low_reg
                      : (reg_addr == `NVM_ADR_ADDR_HIGH) ? addr_high_reg
                      : (reg_addr == `NVM_ADR_CONTROL)   ? ctl_view
                      : (reg_addr == `NVM_ADR_STATUS)    ? {7'h00, write_done_reg}
                      : `NVM_BYTE_ZERO;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata  <= `NVM_BYTE_ZERO;
      write_done <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rd_mux : `NVM_BYTE_ZERO;
      write_done <= done_next;
    end
  end

  // Checks of the sequencing behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  wire ctl_wr_attempt = wr_ctl && reg_wdata[`NVM_BIT_WR] && !reg_wdata[`NVM_BIT_RD]
                        && idle && !warm_rst;

  a_same_cycle_enable: assert property ( // [RQ2]
    ctl_wr_attempt && !write_enable_bit_reg |=> !wr_reg && $stable(state_reg))
    else $error("write started without earlier write enable");

  a_unlock_needed: assert property ( // [RQ18]
    ctl_wr_attempt && lock_reg != nvm_pkg::LK_ARMED |=> !wr_reg)
    else $error("write started without unlock pair");

  a_permit_block: assert property ( // [RQ15]
    ctl_wr_attempt && mss_reg && !permit_sync |=> state_reg == nvm_pkg::ST_IDLE)
    else $error("program write started while not permitted");

  a_write_enable_bit_no_abort: assert property ( // [RQ3]
    state_reg == nvm_pkg::ST_EE_PROG && !prog_last && !warm_rst && wr_ctl
    && !reg_wdata[`NVM_BIT_WRITE_ENABLE_BIT] |=> state_reg == nvm_pkg::ST_EE_PROG && wr_reg)
    else $error("clearing write enable disturbed the write");

  a_done_flag_set: assert property ( // [RQ6]
    prog_done |=> write_done_reg && !wr_reg && write_done)
    else $error("completion did not set flag and clear start");

  a_done_sticky: assert property ( // [RQ6]
    write_done_reg && !wr_stat |=> write_done_reg)
    else $error("done flag dropped without firmware clear");

  a_ee_read_next: assert property ( // [RQ22]
    ee_rd_load && !warm_rst |=> data_low_reg == $past(ee_word) && !rd_reg)
    else $error("data memory read not loaded next cycle");

  a_fl_read_two: assert property ( // [RQ10]
    rd_start && mss_reg && !warm_rst ##1 (!warm_rst)[*2]
    |-> rd_reg ##1 !rd_reg && data_low_reg == $past(fl_word[7:0]))
    else $error("program read not presented after two cycles");

  a_stall_prep: assert property ( // [RQ13]
    wr_start && mss_reg && !warm_rst ##1 (!warm_rst)[*2]
    |-> !core_stall && !$past(core_stall) ##1 core_stall)
    else $error("program write stall not after two prepare cycles");

  a_abort_flag: assert property ( // [RQ21]
    warm_rst && wr_reg |=> abort_reg && !wr_reg && !core_stall)
    else $error("warm reset during write did not flag abort");

  a_select_held: assert property ( // [RQ9]
    busy |=> $stable(mss_reg))
    else $error("space select changed while busy");

  c_ee_write: cover property (ee_done && !warm_rst);
  c_fl_write: cover property (fl_done && !warm_rst);
  c_fl_read:  cover property (fl_rd_load);
  c_abort:    cover property (warm_rst && wr_reg);

endmodule : nvm_read_write_sequencer

//--- bench/core_model.sv
`timescale 1ns/1ns
`include "nvm_defines.svh"
// Firmware side of the core: register traffic as instructions would issue it
module core_model (
  input  wire logic       ref_clk,
  input  wire logic       core_stall,
  input  wire logic [7:0] reg_rdata,
  output logic      [2:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // Strobes idle at time zero; address and data mean nothing until a strobe
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // A stalled core fetches nothing, so it issues no access either
  task automatic wait_run();
    int n;
    n = 0;
    while (core_stall === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_run

  // One write cycle; data lines are scrambled after release so nothing stale is seen
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wait_run();
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  // One read cycle; the answer stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    wait_run();
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Unlock pair then start, back to back; caller has interrupts masked
  task automatic start(input logic [7:0] ctrl);
    wr(3'h5, `NVM_KEY_FIRST);
    wr(3'h5, `NVM_KEY_SECOND);
    wr(3'h4, ctrl);
  endtask : start
endmodule : core_model

//--- bench/tb_nvm_read_write_sequencer.sv
`timescale 1ns/1ns
module tb_nvm_read_write_sequencer;
  logic       ref_clk;
  logic       sys_rst;
  logic       warm_rst;
  logic       program_write_permit;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       core_stall;
  logic       write_done;
  logic [7:0] d;
  int         miscompares;
  int         tests_run;

  // Short programming time keeps the run small
  nvm_read_write_sequencer #(.WRITE_CYCLES(8)) nvm_read_write_sequencer_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .warm_rst(warm_rst),
    .program_write_permit(program_write_permit), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_stall(core_stall), .write_done(write_done));
  core_model core_model_i (
    .ref_clk(ref_clk), .core_stall(core_stall), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    core_model_i.rd(a, d);
    chk(d, exp);
  endtask : rchk

  task automatic wait_done();
    int n;
    n = 0;
    while (write_done !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // A completion that never comes is a mismatch and ends the run
    if (n >= 60) begin
      miscompares++;
      final_report();
    end
  endtask : wait_done

  // Data byte write with wrapped address, enable dropped mid-write, then read back
  task automatic ee_write();
    core_model_i.wr(3'h0, 8'ha5);
    core_model_i.wr(3'h2, 8'h45);
    core_model_i.wr(3'h4, 8'h04);
    core_model_i.start(8'h06);
    rchk(3'h4, 8'h06);
    core_model_i.wr(3'h4, 8'h00);
    wait_done();
    rchk(3'h4, 8'h00);
    rchk(3'h6, 8'h01);
    chk({7'h00, write_done}, 8'h01);
    core_model_i.wr(3'h6, 8'h00);
    rchk(3'h6, 8'h00);
    core_model_i.wr(3'h0, 8'h00);
    core_model_i.wr(3'h2, 8'h05);
    core_model_i.wr(3'h4, 8'h01);
    rchk(3'h0, 8'ha5);
    rchk(3'h0, 8'ha5);
  endtask : ee_write

  // Start refused: enable set in the same write, and a broken unlock pair
  task automatic refused();
    core_model_i.start(8'h06);
    core_model_i.rd(3'h4, d);
    chk(d & 8'h02, 8'h00);
    core_model_i.wr(3'h4, 8'h04);
    core_model_i.wr(3'h5, 8'h55);
    core_model_i.wr(3'h2, 8'h05);
    core_model_i.wr(3'h5, 8'haa);
    core_model_i.wr(3'h4, 8'h06);
    core_model_i.rd(3'h4, d);
    chk(d & 8'h02, 8'h00);
  endtask : refused

  // Program word write at a wrapped address, stall timing, then program read
  task automatic fl_write();
    int n;
    program_write_permit <= 1'b1;
    repeat (4) @(posedge ref_clk);
    core_model_i.wr(3'h0, 8'h5c);
    core_model_i.wr(3'h1, 8'h2b);
    core_model_i.wr(3'h2, 8'h12);
    core_model_i.wr(3'h3, 8'h08);
    core_model_i.wr(3'h4, 8'h84);
    core_model_i.start(8'h86);
    #1;
    chk({7'h00, core_stall}, 8'h00);
    @(posedge ref_clk);
    #1;
    chk({7'h00, core_stall}, 8'h00);
    @(posedge ref_clk);
    #1;
    n = 0;
    while (core_stall === 1'b1 && n < 100) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk(8'(n), 8'h08);
    chk({7'h00, write_done}, 8'h01);
    core_model_i.wr(3'h6, 8'h00);
    core_model_i.wr(3'h0, 8'h00);
    core_model_i.wr(3'h1, 8'h00);
    core_model_i.wr(3'h3, 8'h00);
    core_model_i.wr(3'h4, 8'h81);
    repeat (2) @(posedge ref_clk);
    rchk(3'h0, 8'h5c);
    rchk(3'h1, 8'h2b);
  endtask : fl_write

  // Permit low blocks program writes entirely
  task automatic permit_low();
    program_write_permit <= 1'b0;
    repeat (4) @(posedge ref_clk);
    core_model_i.wr(3'h4, 8'h84);
    core_model_i.start(8'h86);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({7'h00, core_stall}, 8'h00);
    core_model_i.rd(3'h4, d);
    chk(d & 8'h02, 8'h00);
  endtask : permit_low

  // Warm reset in mid-write flags the abort and keeps address and data
  task automatic warm_abort();
    core_model_i.wr(3'h0, 8'h3c);
    core_model_i.wr(3'h2, 8'h07);
    core_model_i.wr(3'h4, 8'h04);
    core_model_i.start(8'h06);
    @(posedge ref_clk);
    warm_rst <= 1'b1;
    @(posedge ref_clk);
    warm_rst <= 1'b0;
    rchk(3'h4, 8'h08);
    rchk(3'h2, 8'h07);
    rchk(3'h0, 8'h3c);
    rchk(3'h7, 8'h00);
    repeat (12) @(posedge ref_clk);
    #1;
    chk({7'h00, write_done}, 8'h00);
  endtask : warm_abort

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // 25 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // A hang is cut short well beyond the expected run length
  initial begin
    #(40 * 4000);
    miscompares++;
    final_report();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    warm_rst = 1'b0;
    program_write_permit = 1'b0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    ee_write();
    refused();
    fl_write();
    permit_low();
    warm_abort();
    final_report();
  end
endmodule : tb_nvm_read_write_sequencer
